// ### rtl/osc_pin_decode.sv
// Purpose: Decode crystal pin pair mode from oscillator control bits
// Assumes: Inputs are register values on the same clock
// Notes: Port mode row wins over the sub-clock rows
`timescale 1ns/1ps
`default_nettype none
module osc_pin_decode (
  input wire pin_mux_pkg::clk0_t c0,
  input wire pin_mux_pkg::clk1_t c1,
  output var pin_mux_pkg::osc_state_t st
);
  always_comb begin
    st = '0;
    if (!c0.sub_oscillator_enable && c0.main_clock_stop && !c1.crystal_pin_select &&
        !c1.stop_mode_bit) begin
      st.port_mode = 1'b1;
    end else if (!c0.sub_clock_select) begin
      if (!c0.main_clock_stop) begin
        st.main_buffer_on = 1'b1;
        st.main_feedback_on = !c1.main_feedback_disable;
      end else if (c1.main_feedback_disable && c1.stop_mode_bit) begin
        st.main_out_pullup = 1'b1;
      end else begin
        st.main_feedback_on = !c1.main_feedback_disable;
      end
    end else if (c0.sub_oscillator_enable) begin
      st.sub_buffer_on = 1'b1;
      st.sub_feedback_on = !c1.sub_feedback_disable;
    end else if (!c1.sub_feedback_disable) begin
      st.sub_feedback_on = 1'b1;
      st.ext_sub_accept = !c1.stop_mode_bit;
    end else begin
      st.sub_out_pullup = c1.stop_mode_bit;
    end
  end
endmodule
`default_nettype wire

// ### rtl/pin_mux_pkg.sv
// Purpose: Shared types and constants for the port pin function selector
// Assumes: 3-bit register address, 8-bit register data
// Notes: Register layouts are carried by the packed structs below
package pin_mux_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  localparam logic [2:0] ADDR_DIR = 3'h0;
  localparam logic [2:0] ADDR_PULLUP = 3'h1;
  localparam logic [2:0] ADDR_PORT_OUT = 3'h2;
  localparam logic [2:0] ADDR_TIMER_SEL = 3'h3;
  localparam logic [2:0] ADDR_IO_CTRL = 3'h4;
  localparam logic [2:0] ADDR_CLK0 = 3'h5;
  localparam logic [2:0] ADDR_CLK1 = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  // Main oscillator stopped after reset, crystal pins in port mode
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [7:0] RST_TIMER_SEL = 8'h00;
  localparam logic [7:0] RST_IO_CTRL = 8'h00;
  localparam logic [7:0] RST_CLK0 = 8'h04;
  localparam logic [7:0] RST_CLK1 = 8'h00;

  // I/O-control codes that select output compare
  localparam logic [2:0] IOC_OC_TOGGLE = 3'h1;
  localparam logic [1:0] IOC_OC_HIGH_BITS = 2'h1;

  typedef struct packed {
    logic [5:0] unused;
    logic chan_d;
    logic chan_c;
  } port_bits_t;

  typedef struct packed {
    logic unused;
    logic chan_d_pwm_mode;
    logic chan_c_pwm_mode;
    logic second_pwm_mode;
    logic chan_d_output_disable;
    logic chan_c_output_disable;
    logic chan_d_route_select;
    logic chan_c_route_select;
  } timer_sel_t;

  typedef struct packed {
    logic unused_hi;
    logic [2:0] chan_d_io_ctrl;
    logic unused_lo;
    logic [2:0] chan_c_io_ctrl;
  } io_ctrl_t;

  typedef struct packed {
    logic [4:0] unused;
    logic main_clock_stop;
    logic sub_oscillator_enable;
    logic sub_clock_select;
  } clk0_t;

  typedef struct packed {
    logic [3:0] unused;
    logic stop_mode_bit;
    logic main_feedback_disable;
    logic sub_feedback_disable;
    logic crystal_pin_select;
  } clk1_t;

  typedef struct packed {
    logic route_select;
    logic output_disable;
    logic second_pwm_mode;
    logic pwm_mode;
    logic [2:0] io_ctrl;
  } timer_chan_cfg_t;

  typedef struct packed {
    logic port_mode;
    logic main_buffer_on;
    logic main_feedback_on;
    logic main_out_pullup;
    logic sub_buffer_on;
    logic sub_feedback_on;
    logic sub_out_pullup;
    logic ext_sub_accept;
  } osc_state_t;

  typedef enum logic [4:0] {
    ROLE_GP_IN = 5'h01,
    ROLE_GP_OUT = 5'h02,
    ROLE_PWM_OUT = 5'h04,
    ROLE_OC_OUT = 5'h08,
    ROLE_CAPTURE = 5'h10
  } pin_role_t;

endpackage

// ### rtl/port_pin_function_select.sv
// Purpose: Function selection for the two timer-shared pins and crystal pins
// Assumes: Single clock mclk at 10 MHz, synchronous active-high reset
// Notes: All pin controls are registered, so they follow settings by one cycle
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_select (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pin_mux_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pin_mux_pkg::DATA_W-1:0] reg_rd_data,
  input wire logic timer_c_wave,
  input wire logic timer_d_wave,
  input wire logic timer_chan_c_pin_in,
  output logic timer_chan_c_pin_out,
  output logic timer_chan_c_pin_oe_n,
  output logic chan_c_pin_pullup_on,
  output logic chan_c_capture_in,
  input wire logic timer_chan_d_pin_in,
  output logic timer_chan_d_pin_out,
  output logic timer_chan_d_pin_oe_n,
  output logic chan_d_pin_pullup_on,
  output logic chan_d_capture_in,
  output var pin_mux_pkg::osc_state_t osc_status
);
  pin_mux_pkg::port_bits_t dir_reg;
  pin_mux_pkg::port_bits_t pullup_reg;
  pin_mux_pkg::port_bits_t port_out_reg;
  pin_mux_pkg::timer_sel_t timer_sel_reg;
  pin_mux_pkg::io_ctrl_t io_ctrl_reg;
  pin_mux_pkg::clk0_t clk0_reg;
  pin_mux_pkg::clk1_t clk1_reg;
  pin_mux_pkg::timer_chan_cfg_t cfg_c;
  pin_mux_pkg::timer_chan_cfg_t cfg_d;
  pin_mux_pkg::pin_role_t role_c;
  pin_mux_pkg::pin_role_t role_d;
  pin_mux_pkg::osc_state_t osc_next;
  logic conflict_c;
  logic conflict_d;
  logic [1:0] sync_c;
  logic [1:0] sync_d;
  logic [pin_mux_pkg::DATA_W-1:0] rd_next;

  function automatic logic role_drives(input pin_mux_pkg::pin_role_t r);
    role_drives = (r == pin_mux_pkg::ROLE_GP_OUT) || (r == pin_mux_pkg::ROLE_PWM_OUT) ||
                  (r == pin_mux_pkg::ROLE_OC_OUT);
  endfunction

  function automatic logic role_is_input(input pin_mux_pkg::pin_role_t r);
    role_is_input = (r == pin_mux_pkg::ROLE_GP_IN) || (r == pin_mux_pkg::ROLE_CAPTURE);
  endfunction

  function automatic logic pin_value(input pin_mux_pkg::pin_role_t r, input logic wave,
                                     input logic port_bit);
    if (r == pin_mux_pkg::ROLE_PWM_OUT || r == pin_mux_pkg::ROLE_OC_OUT) begin
      pin_value = wave;
    end else begin
      pin_value = port_bit;
    end
  endfunction

  // Port registers; unused bits are forced to zero so they read as zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dir_reg <= pin_mux_pkg::RST_PORT;
      pullup_reg <= pin_mux_pkg::RST_PORT;
      port_out_reg <= pin_mux_pkg::RST_PORT;
    end else if (reg_wr) begin
      if (reg_addr == pin_mux_pkg::ADDR_DIR) begin
        dir_reg <= pin_mux_pkg::port_bits_t'({6'h00, reg_wr_data[1:0]});
      end
      if (reg_addr == pin_mux_pkg::ADDR_PULLUP) begin
        pullup_reg <= pin_mux_pkg::port_bits_t'({6'h00, reg_wr_data[1:0]});
      end
      if (reg_addr == pin_mux_pkg::ADDR_PORT_OUT) begin
        port_out_reg <= pin_mux_pkg::port_bits_t'({6'h00, reg_wr_data[1:0]});
      end
    end
  end

  // Timer routing registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_sel_reg <= pin_mux_pkg::RST_TIMER_SEL;
      io_ctrl_reg <= pin_mux_pkg::RST_IO_CTRL;
    end else if (reg_wr) begin
      if (reg_addr == pin_mux_pkg::ADDR_TIMER_SEL) begin
        timer_sel_reg <= pin_mux_pkg::timer_sel_t'({1'b0, reg_wr_data[6:0]});
      end
      if (reg_addr == pin_mux_pkg::ADDR_IO_CTRL) begin
        io_ctrl_reg <= pin_mux_pkg::io_ctrl_t'({1'b0, reg_wr_data[6:4], 1'b0, reg_wr_data[2:0]});
      end
    end
  end

  // Oscillator control registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clk0_reg <= pin_mux_pkg::RST_CLK0;
      clk1_reg <= pin_mux_pkg::RST_CLK1;
    end else if (reg_wr) begin
      if (reg_addr == pin_mux_pkg::ADDR_CLK0) begin
        clk0_reg <= pin_mux_pkg::clk0_t'({5'h00, reg_wr_data[2:0]});
      end
      if (reg_addr == pin_mux_pkg::ADDR_CLK1) begin
        clk1_reg <= pin_mux_pkg::clk1_t'({4'h0, reg_wr_data[3:0]});
      end
    end
  end

  always_comb begin
    cfg_c.route_select = timer_sel_reg.chan_c_route_select;
    cfg_c.output_disable = timer_sel_reg.chan_c_output_disable;
    cfg_c.second_pwm_mode = timer_sel_reg.second_pwm_mode;
    cfg_c.pwm_mode = timer_sel_reg.chan_c_pwm_mode;
    cfg_c.io_ctrl = io_ctrl_reg.chan_c_io_ctrl;
    cfg_d.route_select = timer_sel_reg.chan_d_route_select;
    cfg_d.output_disable = timer_sel_reg.chan_d_output_disable;
    cfg_d.second_pwm_mode = timer_sel_reg.second_pwm_mode;
    cfg_d.pwm_mode = timer_sel_reg.chan_d_pwm_mode;
    cfg_d.io_ctrl = io_ctrl_reg.chan_d_io_ctrl;
  end

  timer_pin_decode u_dec_c (
    .cfg(cfg_c),
    .direction(dir_reg.chan_c),
    .role(role_c),
    .dir_conflict(conflict_c)
  );

  timer_pin_decode u_dec_d (
    .cfg(cfg_d),
    .direction(dir_reg.chan_d),
    .role(role_d),
    .dir_conflict(conflict_d)
  );

  osc_pin_decode u_osc (
    .c0(clk0_reg),
    .c1(clk1_reg),
    .st(osc_next)
  );

  // Pad levels are asynchronous; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_c <= 2'h0;
      sync_d <= 2'h0;
    end else begin
      sync_c <= {sync_c[0], timer_chan_c_pin_in};
      sync_d <= {sync_d[0], timer_chan_d_pin_in};
    end
  end

  // Pin drive; timer wave picks up one cycle of latency here
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_chan_c_pin_out <= 1'b0;
      timer_chan_c_pin_oe_n <= 1'b1;
      timer_chan_d_pin_out <= 1'b0;
      timer_chan_d_pin_oe_n <= 1'b1;
    end else begin
      timer_chan_c_pin_out <= pin_value(role_c, timer_c_wave, port_out_reg.chan_c);
      timer_chan_c_pin_oe_n <= !role_drives(role_c);
      timer_chan_d_pin_out <= pin_value(role_d, timer_d_wave, port_out_reg.chan_d);
      timer_chan_d_pin_oe_n <= !role_drives(role_d);
    end
  end

  // Pull-ups and capture feeds
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chan_c_pin_pullup_on <= 1'b0;
      chan_d_pin_pullup_on <= 1'b0;
      chan_c_capture_in <= 1'b0;
      chan_d_capture_in <= 1'b0;
    end else begin
      chan_c_pin_pullup_on <= role_is_input(role_c) && pullup_reg.chan_c;
      chan_d_pin_pullup_on <= role_is_input(role_d) && pullup_reg.chan_d;
      // Capture sees a quiet low when the pin is not a capture source
      chan_c_capture_in <= (role_c == pin_mux_pkg::ROLE_CAPTURE) && sync_c[1];
      chan_d_capture_in <= (role_d == pin_mux_pkg::ROLE_CAPTURE) && sync_d[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      osc_status <= '0;
    end else begin
      osc_status <= osc_next;
    end
  end

  always_comb begin
    rd_next = 8'h00;
    unique case (reg_addr)
      pin_mux_pkg::ADDR_DIR: rd_next = dir_reg;
      pin_mux_pkg::ADDR_PULLUP: rd_next = pullup_reg;
      pin_mux_pkg::ADDR_PORT_OUT: rd_next = port_out_reg;
      pin_mux_pkg::ADDR_TIMER_SEL: rd_next = timer_sel_reg;
      pin_mux_pkg::ADDR_IO_CTRL: rd_next = io_ctrl_reg;
      pin_mux_pkg::ADDR_CLK0: rd_next = clk0_reg;
      pin_mux_pkg::ADDR_CLK1: rd_next = clk1_reg;
      pin_mux_pkg::ADDR_STATUS: rd_next = {2'h0, osc_status.sub_buffer_on,
                                           osc_status.main_buffer_on, conflict_d, conflict_c,
                                           sync_d[1], sync_c[1]};
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd) begin
      reg_rd_data <= rd_next;
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  chk_c_gp_dir: assert property ((timer_sel_reg.chan_c_route_select ||
      !timer_sel_reg.second_pwm_mode) |=>
      (timer_chan_c_pin_oe_n == !$past(dir_reg.chan_c)))
    else $error("channel C port direction not followed");

  // Same cycle: drive and pull-up are both registered from one combinational role
  chk_c_pullup: assert property (!timer_chan_c_pin_oe_n |->
      !chan_c_pin_pullup_on)
    else $error("pull-up on while channel C pin drives");

  chk_d_gp_out: assert property ((timer_sel_reg.chan_d_route_select &&
      dir_reg.chan_d) |=>
      (!timer_chan_d_pin_oe_n && timer_chan_d_pin_out == $past(port_out_reg.chan_d)))
    else $error("channel D port output not driven");

  chk_d_pullup: assert property ((timer_sel_reg.chan_d_route_select &&
      !dir_reg.chan_d && pullup_reg.chan_d) |=> chan_d_pin_pullup_on)
    else $error("channel D pull-up missing");

  chk_c_pwm_wave: assert property ((!timer_sel_reg.chan_c_route_select &&
      !timer_sel_reg.chan_c_output_disable && timer_sel_reg.second_pwm_mode &&
      timer_sel_reg.chan_c_pwm_mode) |=>
      (!timer_chan_c_pin_oe_n && timer_chan_c_pin_out == $past(timer_c_wave)))
    else $error("channel C PWM wave not on pin");

  chk_d_oc_wave: assert property ((!timer_sel_reg.chan_d_route_select &&
      !timer_sel_reg.chan_d_output_disable && timer_sel_reg.second_pwm_mode &&
      !timer_sel_reg.chan_d_pwm_mode && io_ctrl_reg.chan_d_io_ctrl inside {3'h1, 3'h2, 3'h3}) |=>
      (!timer_chan_d_pin_oe_n && timer_chan_d_pin_out == $past(timer_d_wave)))
    else $error("channel D compare wave not on pin");

  chk_c_capture_path: assert property ((!timer_sel_reg.chan_c_route_select &&
      timer_sel_reg.second_pwm_mode && !timer_sel_reg.chan_c_pwm_mode &&
      io_ctrl_reg.chan_c_io_ctrl[2]) |=>
      (timer_chan_c_pin_oe_n && chan_c_capture_in == $past(sync_c[1])))
    else $error("channel C capture path wrong");

  chk_main_osc_run: assert property ((!clk0_reg.sub_clock_select &&
      clk1_reg.crystal_pin_select && !clk0_reg.main_clock_stop) |=>
      (osc_status.main_buffer_on &&
      osc_status.main_feedback_on == !$past(clk1_reg.main_feedback_disable)))
    else $error("main oscillation buffer state wrong");

  chk_main_stop_pull: assert property ((!clk0_reg.sub_clock_select &&
      clk0_reg.main_clock_stop && clk1_reg.main_feedback_disable && clk1_reg.stop_mode_bit) |=>
      (!osc_status.main_buffer_on && !osc_status.main_feedback_on &&
      osc_status.main_out_pullup))
    else $error("main stop mode pin state wrong");

  chk_sub_osc: assert property ((clk0_reg.sub_clock_select &&
      clk1_reg.crystal_pin_select) |=>
      (osc_status.sub_buffer_on == $past(clk0_reg.sub_oscillator_enable) &&
      osc_status.sub_feedback_on == !$past(clk1_reg.sub_feedback_disable)))
    else $error("sub oscillation buffer state wrong");

  chk_sub_off_pull: assert property ((clk0_reg.sub_clock_select &&
      clk1_reg.crystal_pin_select && !clk0_reg.sub_oscillator_enable &&
      clk1_reg.sub_feedback_disable) |=>
      (!osc_status.sub_buffer_on && !osc_status.sub_feedback_on &&
      osc_status.sub_out_pullup == $past(clk1_reg.stop_mode_bit)))
    else $error("sub stop pin state wrong");

  // Timer claim must drive the wave even with the port direction at input
  chk_timer_priority: assert property (((role_c == pin_mux_pkg::ROLE_PWM_OUT ||
      role_c == pin_mux_pkg::ROLE_OC_OUT) && !dir_reg.chan_c) |=>
      (!timer_chan_c_pin_oe_n && timer_chan_c_pin_out == $past(timer_c_wave)))
    else $error("channel C timer output loses to port");

  cov_c_pwm: cover property (role_c == pin_mux_pkg::ROLE_PWM_OUT ##1 !timer_chan_c_pin_oe_n);
  cov_d_capture: cover property (role_d == pin_mux_pkg::ROLE_CAPTURE ##1 chan_d_capture_in);
  cov_main_run: cover property (osc_status.main_buffer_on);
  cov_sub_ext: cover property (osc_status.ext_sub_accept);

endmodule
`default_nettype wire

// ### rtl/timer_pin_decode.sv
// Purpose: Decode the role of one timer-shared port pin
// Assumes: Inputs are register values on the same clock
// Notes: Purely combinational, one instance per channel
`timescale 1ns/1ps
`default_nettype none
module timer_pin_decode (
  input wire pin_mux_pkg::timer_chan_cfg_t cfg,
  input wire logic direction,
  output var pin_mux_pkg::pin_role_t role,
  output logic dir_conflict
);
  logic route_ok;
  logic pwm_hit;
  logic oc_hit;
  logic cap_hit;

  always_comb begin
    route_ok = !cfg.route_select && cfg.second_pwm_mode;
    pwm_hit = route_ok && !cfg.output_disable && cfg.pwm_mode;
    oc_hit = route_ok && !cfg.output_disable && !cfg.pwm_mode &&
             (cfg.io_ctrl == pin_mux_pkg::IOC_OC_TOGGLE ||
              cfg.io_ctrl[2:1] == pin_mux_pkg::IOC_OC_HIGH_BITS);
    // Capture ignores the output-disable bit
    cap_hit = route_ok && !cfg.pwm_mode && cfg.io_ctrl[2];
    // Timer beats the port; direction picks the role only when unclaimed
    if (pwm_hit) begin
      role = pin_mux_pkg::ROLE_PWM_OUT;
    end else if (oc_hit) begin
      role = pin_mux_pkg::ROLE_OC_OUT;
    end else if (cap_hit) begin
      role = pin_mux_pkg::ROLE_CAPTURE;
    end else if (direction) begin
      role = pin_mux_pkg::ROLE_GP_OUT;
    end else begin
      role = pin_mux_pkg::ROLE_GP_IN;
    end
    dir_conflict = cap_hit && direction;
  end
endmodule
`default_nettype wire

// ### verification/port_pin_function_select_bench.sv
// Purpose: Self-checking bench for the port pin function selector
// Assumes: Pin controls follow a register write by one registered stage
// Notes: Random settings are compared against a bench-side model
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_select_bench;
  localparam logic [7:0] MASK [7] = '{8'h03, 8'h03, 8'h03, 8'h7F, 8'h77, 8'h07, 8'h0F};
  localparam logic [7:0] RSTV [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rd_data;
  logic wave_c = 1'b0, wave_d = 1'b0, pad_c = 1'b0, pad_d = 1'b0;
  logic out_c, oe_n_c, pu_c, cap_c, out_d, oe_n_d, pu_d, cap_d;
  pin_mux_pkg::osc_state_t osc_status;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000004A;
  logic [7:0] rv [7];
  logic [7:0] d;
  logic [31:0] r, r2;
  logic [7:0] t;

  port_pin_function_select dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .timer_c_wave(wave_c), .timer_d_wave(wave_d), .timer_chan_c_pin_in(pad_c),
    .timer_chan_c_pin_out(out_c), .timer_chan_c_pin_oe_n(oe_n_c), .chan_c_pin_pullup_on(pu_c),
    .chan_c_capture_in(cap_c), .timer_chan_d_pin_in(pad_d), .timer_chan_d_pin_out(out_d),
    .timer_chan_d_pin_oe_n(oe_n_d), .chan_d_pin_pullup_on(pu_d), .chan_d_capture_in(cap_d),
    .osc_status(osc_status));

  initial begin
    forever #50 mclk = ~mclk;
  end

  // Hang guard, far above the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("unexpected at %0t: run timed out", $time);
      end_of_test();
    end
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Returns {conflict, oe_n, out, pullup, capture}
  function automatic logic [4:0] chan_model(input int ch, input logic dir, pu, po, wave, pad);
    logic route, dis, p2, pwm, drive, capr;
    logic [2:0] ioc;
    route = rv[3][ch];
    dis = rv[3][2+ch];
    p2 = rv[3][4];
    pwm = rv[3][5+ch];
    ioc = (ch == 1) ? rv[4][6:4] : rv[4][2:0];
    drive = !route && !dis && p2 && (pwm || ioc == 3'h1 || ioc[2:1] == 2'h1);
    capr = !route && p2 && !pwm && ioc[2];
    if (drive) return {1'b0, 1'b0, wave, 1'b0, 1'b0};
    if (capr) return {dir, 1'b1, 1'b0, pu, pad};
    if (dir) return {1'b0, 1'b0, po, 1'b0, 1'b0};
    return {1'b0, 1'b1, 1'b0, pu, 1'b0};
  endfunction

  // Returns {valid, status}; rows left open by the tables are not judged
  function automatic logic [8:0] osc_model(input logic [7:0] c0, c1);
    logic sel, oe, ms, ps, sfd, mfd, stp;
    {ms, oe, sel} = c0[2:0];
    {stp, mfd, sfd, ps} = c1[3:0];
    if (!oe && ms && !ps && !stp) return {1'b1, 8'h80};
    if (!sel && ps) begin
      if (stp && !(ms && mfd)) return 9'h000;
      return {1'b1, 1'b0, !ms, !mfd, stp, 4'h0};
    end
    if (sel) begin
      if (oe) return stp ? 9'h000 : {5'h10, 1'b1, !sfd, 2'h0};
      if (!sfd) return stp ? 9'h000 : 9'h105;
      return {1'b1, 6'h00, stp, 1'b0};
    end
    return 9'h000;
  endfunction

  task automatic check(input logic [7:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a != 3'h7) rv[a] = v & MASK[a];
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rd_data;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rv = RSTV;
    @(posedge mclk);
    #1 check(osc_status, 8'h80, "osc after reset");
    check({6'h00, oe_n_d, oe_n_c}, 8'h03, "oe_n after reset");
    for (int a = 0; a < 7; a++) begin
      rd(a[2:0], d);
      check(d, RSTV[a], "reset value");
    end
    $display("test reset done");
  endtask

  task automatic check_pins(input logic with_status);
    logic [4:0] ec, ed;
    logic [8:0] eo;
    logic [7:0] st;
    ec = chan_model(0, rv[0][0], rv[1][0], rv[2][0], wave_c, pad_c);
    ed = chan_model(1, rv[0][1], rv[1][1], rv[2][1], wave_d, pad_d);
    eo = osc_model(rv[5], rv[6]);
    check(8'(oe_n_c), 8'(ec[3]), "oe_n c");
    if (!ec[3]) check(8'(out_c), 8'(ec[2]), "out c");
    check(8'(pu_c), 8'(ec[1]), "pullup c");
    check(8'(cap_c), 8'(ec[0]), "capture c");
    check(8'(oe_n_d), 8'(ed[3]), "oe_n d");
    if (!ed[3]) check(8'(out_d), 8'(ed[2]), "out d");
    check(8'(pu_d), 8'(ed[1]), "pullup d");
    check(8'(cap_d), 8'(ed[0]), "capture d");
    if (eo[8]) check(osc_status, eo[7:0], "osc");
    if (with_status) begin
      rd(3'h7, st);
      if (eo[8]) check(st, {2'h0, eo[3], eo[6], ed[4], ec[4], pad_d, pad_c}, "status");
      else check(st & 8'h0F, {4'h0, ed[4], ec[4], pad_d, pad_c}, "status");
    end
  endtask

  initial begin
    do_reset();
    for (int a = 0; a < 7; a++) begin
      wr(a[2:0], 8'hFF);
      rd(a[2:0], d);
      check(d, MASK[a], "readback");
    end
    wr(3'h7, 8'hFF);
    rd(3'h0, d);
    @(posedge mclk);
    #1 check(reg_rd_data, 8'h00, "read data lingers");
    $display("test register access done");
    for (int i = 0; i < 250; i++) begin
      r = xorshift();
      r2 = xorshift();
      t = {1'b0, r[12:6]};
      if (r[29]) t = (t & 8'hFC) | 8'h10;
      @(posedge mclk);
      wave_c <= r2[0];
      wave_d <= r2[1];
      pad_c <= r2[2];
      pad_d <= r2[3];
      wr(3'h0, {6'h00, r[1:0]});
      wr(3'h1, {6'h00, r[3:2]});
      wr(3'h2, {6'h00, r[5:4]});
      wr(3'h3, t);
      wr(3'h4, r[21:14]);
      wr(3'h5, {5'h00, r[24:22]});
      wr(3'h6, {4'h0, r[28:25]});
      repeat (4) @(posedge mclk);
      #1 check_pins(1'b1);
      @(posedge mclk);
      wave_c <= ~wave_c;
      wave_d <= ~wave_d;
      @(posedge mclk);
      #1 check_pins(1'b0);
    end
    $display("test random settings done");
    do_reset();
    end_of_test();
  end

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
